/* File: verilog/cac_pkg.sv */
// package: shared constants of the comparator control block
package cac_pkg;
  // counts and widths
  localparam int unsigned NUM_CMP = 2;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned POS_SRC = 10;
  localparam int unsigned NEG_SRC = 13;
  localparam int unsigned DIV_W = 4;
  // register offsets
  localparam logic [7:0] OFS_CMP0_CONTROL = 8'h00;
  localparam logic [7:0] OFS_CMP1_CONTROL = 8'h04;
  localparam logic [7:0] OFS_STATE0 = 8'h08;
  localparam logic [7:0] OFS_STATE1 = 8'h0C;
  localparam logic [7:0] OFS_CMP0_OUTPUT_ROUTING = 8'h10;
  localparam logic [7:0] OFS_CMP1_OUTPUT_ROUTING = 8'h14;
  localparam logic [7:0] OFS_PEND0 = 8'h18;
  localparam logic [7:0] OFS_PEND1 = 8'h1C;
  localparam logic [7:0] OFS_MASK0 = 8'h20;
  localparam logic [7:0] OFS_MASK1 = 8'h24;
  localparam logic [7:0] OFS_RAW0 = 8'h28;
  localparam logic [7:0] OFS_RAW1 = 8'h2C;
  localparam logic [7:0] OFS_ACK0 = 8'h30;
  localparam logic [7:0] OFS_ACK1 = 8'h34;
  localparam logic [7:0] OFS_SRST0 = 8'h38;
  localparam logic [7:0] OFS_SRST1 = 8'h3C;
  localparam logic [7:0] OFS_CLOCK = 8'h48;
  // control field positions
  localparam int unsigned B_EDGE = 31;
  localparam int unsigned B_POL = 30;
  localparam int unsigned B_FALL = 29;
  localparam int unsigned B_RISE = 28;
  localparam int unsigned B_IDLE = 27;
  localparam int unsigned B_MUX = 26;
  localparam int unsigned POS_LO = 22;
  localparam int unsigned NEG_LO = 18;
  localparam int unsigned LVL_LO = 12;
  localparam int unsigned B_ON = 0;
  // source codes
  localparam logic [3:0] SEL_LAST_POS = 4'h9;
  localparam logic [3:0] SEL_SCALED = 4'hC;
  // flag, status, clock bit positions
  localparam int unsigned F_OUT = 0;
  localparam int unsigned F_PULSE = 1;
  localparam int unsigned S_ACTIVE = 1;
  localparam int unsigned B_DIV_RST = 4;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h4000_0000;
  localparam logic [1:0] MASK_RST = 2'h3;
endpackage : cac_pkg

/* File: verilog/cac_chan_if.sv */
// interface: link between register bank and one comparator channel
`timescale 1ns/1ps
`default_nettype none
interface cac_chan_if;
  logic [31:0] ctrl;
  logic soft_rst;
  logic [1:0] ack;
  logic sample_en;
  logic cmp_raw;
  logic cmp_out;
  logic edge_pulse;
  logic [1:0] raw_flags;
  modport bank (output ctrl, soft_rst, ack, sample_en, cmp_raw,
    input cmp_out, edge_pulse, raw_flags);
  modport chan (input ctrl, soft_rst, ack, sample_en, cmp_raw,
    output cmp_out, edge_pulse, raw_flags);
endinterface : cac_chan_if
`default_nettype wire

/* File: verilog/cac_div.sv */
// module: sample rate divider giving a one-cycle enable pulse
`timescale 1ns/1ps
`default_nettype none
module cac_div #(
  parameter int unsigned W = cac_pkg::DIV_W
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // control
  input wire logic clear_i,
  input wire logic [W-1:0] div_i,
  // enable pulse
  output logic tick_o
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } cac_div_t;
  cac_div_t s;
  cac_div_t next_s;
  // count up to the divide value, then pulse
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (clear_i) begin
      next_s.cnt = '0;
    end else if (s.cnt >= div_i) begin
      next_s.cnt = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + W'(1);
    end
  end
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign tick_o = s.tick;
endmodule : cac_div
`default_nettype wire

/* File: verilog/cac_chan.sv */
// module: one comparator channel, output hold, edges and raw flags
`timescale 1ns/1ps
`default_nettype none
module cac_chan (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // link to register bank
  cac_chan_if.chan ch
);
  typedef struct packed {
    logic out;
    logic pulse;
    logic [1:0] flags;
  } cac_chan_t;
  cac_chan_t s;
  cac_chan_t next_s;
  logic active;
  logic rise;
  logic fall;
  logic irq_evt;
  logic pulse_evt;
  // output value, edge detection and sticky flags
  always_comb begin
    next_s = s;
    active = ch.ctrl[cac_pkg::B_ON];
    if (!active) begin
      next_s.out = ch.ctrl[cac_pkg::B_IDLE];
    end else if (ch.sample_en) begin
      next_s.out = ch.cmp_raw;
    end
    rise = active && next_s.out && !s.out;
    fall = active && !next_s.out && s.out;
    pulse_evt = (rise && ch.ctrl[cac_pkg::B_RISE])
      || (fall && ch.ctrl[cac_pkg::B_FALL]);
    if (ch.ctrl[cac_pkg::B_EDGE]) begin
      irq_evt = ch.ctrl[cac_pkg::B_POL] ? rise : fall;
    end else begin
      irq_evt = active && (next_s.out == ch.ctrl[cac_pkg::B_POL]);
    end
    next_s.pulse = pulse_evt;
    // set wins over a clear in the same cycle
    next_s.flags = (s.flags & ~ch.ack) | {pulse_evt, irq_evt};
    if (ch.soft_rst) begin
      next_s = '0;
      next_s.out = ch.ctrl[cac_pkg::B_IDLE];
    end
  end
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign ch.cmp_out = s.out;
  assign ch.edge_pulse = s.pulse;
  assign ch.raw_flags = s.flags;
endmodule : cac_chan
`default_nettype wire

/* File: verilog/cac_top.sv */
// module: register bank and source decode of the comparator pair
//
// Overview of operation
// - control bit 31 picks level (0) or edge (1) interrupt, reset 0
// - control bit 30 picks low/falling (0) or high/rising (1), reset 1
// - bit 29 enables an edge pulse on each falling output edge
// - bit 28 enables an edge pulse on each rising output edge
// - an inactive comparator outputs the constant in bit 27
// - positive select 25:22: 0-7 pins, 8 and 9 converter outputs
// - per-comparator registers interleaved 0x00-0x3C, clock at 0x48
// - masks reset to 0x3; status, raw, clear, route, reset to zero
// - negative select 21:18 adds reference, ground, scaled supply
// - second control register has the same field layout
`timescale 1ns/1ps
`default_nettype none
module cac_top #(
  parameter int unsigned DIV_W = cac_pkg::DIV_W
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // register port
  input wire logic [cac_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  // analog comparator results
  input wire logic [1:0] cmp_raw_i,
  // analog front end control
  output logic [1:0] cmp_on_o,
  output logic [1:0] mux_on_o,
  output logic [1:0][cac_pkg::POS_SRC-1:0] pos_pick_o,
  output logic [1:0][cac_pkg::NEG_SRC-1:0] neg_pick_o,
  output logic [1:0][5:0] level_sel_o,
  // digital results
  output logic [1:0] cmp_out_o,
  output logic [1:0] route_on_o,
  output logic [1:0] edge_pulse_o,
  output logic [1:0] irq_o
);

  // register state
  typedef struct packed {
    logic [1:0][31:0] ctrl;
    logic [1:0] route;
    logic [1:0][1:0] mask;
    logic [1:0] srst;
    logic [4:0] clk_cfg;
    logic [31:0] rdata;
  } cac_regs_t;

  cac_regs_t s;
  cac_regs_t next_s;

  // channel links
  cac_chan_if ch_if[cac_pkg::NUM_CMP]();

  // channel outputs gathered
  logic [1:0] ch_out;
  logic [1:0] ch_pulse;
  logic [1:0][1:0] ch_flags;
  logic [1:0][1:0] pending;
  logic [1:0][1:0] ack;
  logic tick;
  logic [31:0] rd_mux;

  // positive source decode, nothing picked while mux is off
  function automatic logic [cac_pkg::POS_SRC-1:0] pick_pos(
    input logic [3:0] code,
    input logic en
  );
    logic [cac_pkg::POS_SRC-1:0] r;
    r = '0;
    if (en && code <= cac_pkg::SEL_LAST_POS) begin
      r[code] = 1'b1;
    end
    return r;
  endfunction : pick_pos

  // negative source decode, codes from 0xC share the scaled supply
  function automatic logic [cac_pkg::NEG_SRC-1:0] pick_neg(
    input logic [3:0] code,
    input logic en
  );
    logic [cac_pkg::NEG_SRC-1:0] r;
    r = '0;
    if (!en) begin
      r = '0;
    end else if (code >= cac_pkg::SEL_SCALED) begin
      r[cac_pkg::NEG_SRC-1] = 1'b1;
    end else begin
      r[code] = 1'b1;
    end
    return r;
  endfunction : pick_neg

  // shared sample rate divider
  cac_div #(
    .W(DIV_W)
  ) u_div (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .clear_i(s.clk_cfg[cac_pkg::B_DIV_RST]),
    .div_i(s.clk_cfg[DIV_W-1:0]),
    .tick_o(tick)
  );

  // one channel per comparator
  for (genvar g = 0; g < cac_pkg::NUM_CMP; g++) begin : g_chan
    assign ch_if[g].ctrl = s.ctrl[g];
    assign ch_if[g].soft_rst = s.srst[g];
    assign ch_if[g].ack = ack[g];
    assign ch_if[g].sample_en = tick;
    assign ch_if[g].cmp_raw = cmp_raw_i[g];
    assign ch_out[g] = ch_if[g].cmp_out;
    assign ch_pulse[g] = ch_if[g].edge_pulse;
    assign ch_flags[g] = ch_if[g].raw_flags;

    cac_chan u_chan (
      .sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .ch(ch_if[g])
    );

    // pending view and interrupt line
    assign pending[g] = ch_flags[g] & ~s.mask[g];
    assign irq_o[g] = |pending[g];

    // analog front end drive
    assign cmp_on_o[g] = s.ctrl[g][cac_pkg::B_ON];
    assign mux_on_o[g] = s.ctrl[g][cac_pkg::B_MUX];
    assign pos_pick_o[g] = pick_pos(
      s.ctrl[g][cac_pkg::POS_LO +: 4],
      s.ctrl[g][cac_pkg::B_MUX]);
    assign neg_pick_o[g] = pick_neg(
      s.ctrl[g][cac_pkg::NEG_LO +: 4],
      s.ctrl[g][cac_pkg::B_MUX]);
    assign level_sel_o[g] = s.ctrl[g][cac_pkg::LVL_LO +: 6];
  end : g_chan

  // clear pulses from writes to the acknowledge registers
  always_comb begin
    ack = '0;
    if (reg_we_i && reg_addr_i == cac_pkg::OFS_ACK0) begin
      ack[0] = reg_wdata_i[1:0];
    end
    if (reg_we_i && reg_addr_i == cac_pkg::OFS_ACK1) begin
      ack[1] = reg_wdata_i[1:0];
    end
  end

  // read data select, unmapped reads give zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (reg_addr_i)
      cac_pkg::OFS_CMP0_CONTROL: begin
        rd_mux = s.ctrl[0];
      end
      cac_pkg::OFS_CMP1_CONTROL: begin
        rd_mux = s.ctrl[1];
      end
      cac_pkg::OFS_STATE0: begin
        rd_mux[cac_pkg::F_OUT] = ch_out[0];
        rd_mux[cac_pkg::S_ACTIVE] = s.ctrl[0][cac_pkg::B_ON];
      end
      cac_pkg::OFS_STATE1: begin
        rd_mux[cac_pkg::F_OUT] = ch_out[1];
        rd_mux[cac_pkg::S_ACTIVE] = s.ctrl[1][cac_pkg::B_ON];
      end
      cac_pkg::OFS_CMP0_OUTPUT_ROUTING: begin
        rd_mux[0] = s.route[0];
      end
      cac_pkg::OFS_CMP1_OUTPUT_ROUTING: begin
        rd_mux[0] = s.route[1];
      end
      cac_pkg::OFS_PEND0: begin
        rd_mux[1:0] = pending[0];
      end
      cac_pkg::OFS_PEND1: begin
        rd_mux[1:0] = pending[1];
      end
      cac_pkg::OFS_MASK0: begin
        rd_mux[1:0] = s.mask[0];
      end
      cac_pkg::OFS_MASK1: begin
        rd_mux[1:0] = s.mask[1];
      end
      cac_pkg::OFS_RAW0: begin
        rd_mux[1:0] = ch_flags[0];
      end
      cac_pkg::OFS_RAW1: begin
        rd_mux[1:0] = ch_flags[1];
      end
      cac_pkg::OFS_SRST0: begin
        rd_mux[0] = s.srst[0];
      end
      cac_pkg::OFS_SRST1: begin
        rd_mux[0] = s.srst[1];
      end
      cac_pkg::OFS_CLOCK: begin
        rd_mux[4:0] = s.clk_cfg;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // register writes and read data capture
  always_comb begin
    next_s = s;
    next_s.rdata = reg_re_i ? rd_mux : 32'h0000_0000;
    if (reg_we_i) begin
      case (reg_addr_i)
        cac_pkg::OFS_CMP0_CONTROL: begin
          next_s.ctrl[0] = reg_wdata_i;
        end
        cac_pkg::OFS_CMP1_CONTROL: begin
          next_s.ctrl[1] = reg_wdata_i;
        end
        cac_pkg::OFS_CMP0_OUTPUT_ROUTING: begin
          next_s.route[0] = reg_wdata_i[0];
        end
        cac_pkg::OFS_CMP1_OUTPUT_ROUTING: begin
          next_s.route[1] = reg_wdata_i[0];
        end
        cac_pkg::OFS_MASK0: begin
          next_s.mask[0] = reg_wdata_i[1:0];
        end
        cac_pkg::OFS_MASK1: begin
          next_s.mask[1] = reg_wdata_i[1:0];
        end
        cac_pkg::OFS_SRST0: begin
          next_s.srst[0] = reg_wdata_i[0];
        end
        cac_pkg::OFS_SRST1: begin
          next_s.srst[1] = reg_wdata_i[0];
        end
        cac_pkg::OFS_CLOCK: begin
          next_s.clk_cfg = reg_wdata_i[4:0];
        end
        default: begin
          next_s.clk_cfg = s.clk_cfg;
        end
      endcase
    end
  end

  // state register with documented reset values
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '0;
      s.ctrl[0] <= cac_pkg::CTRL_RST;
      s.ctrl[1] <= cac_pkg::CTRL_RST;
      s.mask[0] <= cac_pkg::MASK_RST;
      s.mask[1] <= cac_pkg::MASK_RST;
    end else begin
      s <= next_s;
    end
  end

  // outputs
  assign reg_rdata_o = s.rdata;
  assign cmp_out_o = ch_out;
  assign route_on_o = s.route;
  assign edge_pulse_o = ch_pulse;

endmodule : cac_top
`default_nettype wire

/* File: testbench/cac_checker.sv */
// checker: port-level properties of the comparator control block
`timescale 1ns/1ps
`default_nettype none
module cac_checker (
  // clock, reset and register port
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [31:0] reg_rdata_o,
  // front end and results
  input wire logic [1:0] cmp_on_o,
  input wire logic [1:0] mux_on_o,
  input wire logic [1:0][9:0] pos_pick_o,
  input wire logic [1:0][12:0] neg_pick_o,
  input wire logic [1:0] cmp_out_o,
  input wire logic [1:0] edge_pulse_o,
  input wire logic [1:0] irq_o
);
  logic [31:0] c0, c1;
  logic [1:0] m0;
  logic [3:0] ps, ns;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // shadow copies of both control registers and the first mask register
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      c0 <= cac_pkg::CTRL_RST;
      c1 <= cac_pkg::CTRL_RST;
      m0 <= cac_pkg::MASK_RST;
    end else begin
      if (reg_we_i && reg_addr_i == 8'h00) c0 <= reg_wdata_i;
      if (reg_we_i && reg_addr_i == 8'h04) c1 <= reg_wdata_i;
      if (reg_we_i && reg_addr_i == 8'h20) m0 <= reg_wdata_i[1:0];
    end
  end
  // select fields of the first control register
  assign ps = c0[25:22];
  assign ns = c0[21:18];
  property p_rd_slot;
    reg_rdata_o != 32'h0 |-> $past(reg_re_i);
  endproperty
  a_rd_slot: assert property (p_rd_slot) else $error("stray read data");
  property p_ctl_rd;
    $past(reg_re_i) && $past(reg_addr_i) == 8'h00 |-> reg_rdata_o == $past(c0);
  endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("control readback");
  property p_fields;
    {mux_on_o, cmp_on_o} == {c1[26], c0[26], c1[0], c0[0]};
  endproperty
  a_fields: assert property (p_fields) else $error("enable fields");
  property p_pos;
    pos_pick_o[0] == ((c0[26] && ps <= 4'h9) ? 10'h1 << ps : 10'h0);
  endproperty
  a_pos: assert property (p_pos) else $error("positive pick");
  property p_neg;
    neg_pick_o[0] == (!c0[26] ? 13'h0 : ns >= 4'hC ? 13'h1000 : 13'h1 << ns);
  endproperty
  a_neg: assert property (p_neg) else $error("negative pick");
  property p_idle;
    !$past(cmp_on_o[0]) |-> cmp_out_o[0] == $past(c0[27]);
  endproperty
  a_idle: assert property (p_idle) else $error("idle output");
  property p_pulse_src;
    edge_pulse_o[0] |-> ($rose(cmp_out_o[0]) && $past(c0[28]))
      || ($fell(cmp_out_o[0]) && $past(c0[29]));
  endproperty
  a_pulse_src: assert property (p_pulse_src) else $error("stray pulse");
  property p_rise;
    $rose(cmp_out_o[0]) && $past(c0[28]) && $past(cmp_on_o[0])
      && $past(cmp_on_o[0], 2) |-> edge_pulse_o[0];
  endproperty
  a_rise: assert property (p_rise) else $error("missed rise pulse");
  property p_masked;
    m0 == 2'h3 |-> !irq_o[0];
  endproperty
  a_masked: assert property (p_masked) else $error("masked irq");
endmodule : cac_checker
`default_nettype wire

/* File: testbench/cac_front_model.sv */
// model: analog sources and comparator decision for both channels
`timescale 1ns/1ps
`default_nettype none
module cac_front_model (
  // clock and source levels
  input wire logic sys_clk_i,
  input wire logic [9:0] pos_hi_i,
  input wire logic [12:0] neg_hi_i,
  // picks from the block
  input wire logic [1:0][9:0] pos_pick_i,
  input wire logic [1:0][12:0] neg_pick_i,
  // comparator decisions
  output logic [1:0] cmp_raw_o
);
  initial cmp_raw_o = 2'h0;
  // an open input gives a result that toggles every cycle
  always @(posedge sys_clk_i) begin
    for (int i = 0; i < 2; i++) begin
      if (pos_pick_i[i] == 10'h0 || neg_pick_i[i] == 13'h0)
        cmp_raw_o[i] <= ~cmp_raw_o[i];
      else
        cmp_raw_o[i] <= |(pos_pick_i[i] & pos_hi_i)
          & ~|(neg_pick_i[i] & neg_hi_i);
    end
  end
endmodule : cac_front_model
`default_nettype wire

/* File: testbench/test_analog_comparator_control.sv */
// bench: register and comparator path tests of the control block
`timescale 1ns/1ps
`default_nettype none
module test_analog_comparator_control;
  logic sys_clk_i, nrst_i, reg_we_i, reg_re_i;
  logic [7:0] reg_addr_i, a;
  logic [31:0] reg_wdata_i, reg_rdata_o, r, x;
  logic [1:0] cmp_raw_i, cmp_on_o, mux_on_o, cmp_out_o;
  logic [1:0] route_on_o, edge_pulse_o, irq_o;
  logic [1:0][9:0] pos_pick_o;
  logic [1:0][12:0] neg_pick_o;
  logic [1:0][5:0] level_sel_o;
  logic [9:0] pos_hi;
  logic [12:0] neg_hi;
  logic [3:0] s;
  logic ed, pl, fl, rs;
  int errors, comparisons, cycles, pulses, p0;
  cac_top dut (.sys_clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_we_i,
    .reg_re_i, .reg_rdata_o, .cmp_raw_i, .cmp_on_o, .mux_on_o, .pos_pick_o,
    .neg_pick_o, .level_sel_o, .cmp_out_o, .route_on_o, .edge_pulse_o,
    .irq_o);
  cac_front_model far (.sys_clk_i, .pos_hi_i(pos_hi), .neg_hi_i(neg_hi),
    .pos_pick_i(pos_pick_o), .neg_pick_i(neg_pick_o), .cmp_raw_o(cmp_raw_i));
  // clock
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // cycle ceiling and edge pulse count
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (edge_pulse_o[0] === 1'b1) pulses <= pulses + 1;
    if (cycles == 5000) begin
      errors = errors + 1;
      finish_test();
    end
  end
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    reg_we_i <= 1'b1;
    reg_addr_i <= ad;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_we_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask : wr
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic chk_reg(input logic [7:0] ad, input logic [31:0] e);
    reg_re_i <= 1'b1;
    reg_addr_i <= ad;
    @(posedge sys_clk_i);
    reg_re_i <= 1'b0;
    #1 r = reg_rdata_o;
    @(posedge sys_clk_i);
    chk(r, e);
  endtask : chk_reg
  task automatic finish_test();
    if (errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  // main sequence
  initial begin
    {nrst_i, reg_we_i, reg_re_i, reg_addr_i, reg_wdata_i} = '0;
    {pos_hi, neg_hi, errors, comparisons, cycles, pulses} = '0;
    repeat (3) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    @(posedge sys_clk_i);
    // reset values of every slot up to the clock register
    for (int i = 0; i < 19; i++) begin
      a = 8'(i * 4);
      x = a < 8'h08 ? 32'h4000_0000 : (a == 8'h20 || a == 8'h24) ? 32'h3 : 0;
      chk_reg(a, x);
    end
    // read-only state, mask width, route bit
    wr(8'h08, 32'hFFFF_FFFF);
    chk_reg(8'h08, 32'h0);
    wr(8'h20, 32'hFFFF_FFFC);
    chk_reg(8'h20, 32'h0);
    wr(8'h10, 32'h1);
    chk(32'(route_on_o), 32'h1);
    // every select code on both channels
    for (int c = 0; c < 2; c++) begin
      for (int k = 0; k < 16; k++) begin
        s = 4'(k);
        wr(8'(c * 4), {5'h0, 1'b1, s, s, 2'h0, s, 12'h0});
        chk(32'(pos_pick_o[c]), k < 10 ? 32'h1 << k : 0);
        chk(32'(neg_pick_o[c]), k < 12 ? 32'h1 << k : 32'h1000);
        chk(32'(level_sel_o[c]), 32'(k));
      end
    end
    wr(8'h00, 32'h0240_0000);
    chk(32'(pos_pick_o[0]), 32'h0);
    // inactive output follows the idle value
    wr(8'h00, 32'h0800_0000);
    @(posedge sys_clk_i);
    chk(32'(cmp_out_o[0]), 32'h1);
    wr(8'h00, 32'h0);
    @(posedge sys_clk_i);
    chk(32'(cmp_out_o[0]), 32'h0);
    // both modes, both senses, each pulse enable
    for (int i = 0; i < 4; i++) begin
      {ed, pl, fl, rs} = {i[1], i[0] ^ i[1], i[1], i[0]};
      wr(8'h00, {ed, pl, fl, rs, 2'b01, 4'h0, 4'hB, 18'h0});
      wr(8'h00, {ed, pl, fl, rs, 2'b01, 4'h0, 4'hB, 18'h1});
      wr(8'h30, 32'h3);
      p0 = pulses;
      pos_hi <= 10'h1;
      repeat (4) @(posedge sys_clk_i);
      chk_reg(8'h28, {30'h0, rs, !ed | pl});
      chk_reg(8'h18, {30'h0, rs, !ed | pl});
      chk(32'(irq_o[0]), 32'h1);
      chk(32'(pulses - p0), 32'(rs));
      wr(8'h30, 32'h3);
      chk_reg(8'h28, {31'h0, !ed && pl});
      pos_hi <= 10'h0;
      repeat (4) @(posedge sys_clk_i);
      chk_reg(8'h28, {30'h0, fl, !(ed && pl)});
      chk(32'(pulses - p0), 32'(rs) + 32'(fl));
    end
    wr(8'h20, 32'h3);
    chk(32'(irq_o[0]), 32'h0);
    chk_reg(8'h18, 32'h0);
    // soft reset of channel one forces its idle value
    wr(8'h04, 32'h0C40_0000);
    wr(8'h04, 32'h0C40_0001);
    repeat (3) @(posedge sys_clk_i);
    chk(32'(cmp_out_o[1]), 32'h0);
    wr(8'h3C, 32'h1);
    @(posedge sys_clk_i);
    chk(32'(cmp_out_o[1]), 32'h1);
    chk_reg(8'h3C, 32'h1);
    // channel one: rising edge irq and pulse at a divided sample rate
    wr(8'h04, 32'hD440_0001);
    wr(8'h3C, 32'h0);
    wr(8'h24, 32'h0);
    wr(8'h48, 32'h13);
    wr(8'h48, 32'h3);
    pos_hi <= 10'h2;
    repeat (4) @(posedge sys_clk_i);
    chk(32'(cmp_out_o[1]), 32'h0);
    @(posedge sys_clk_i);
    chk(32'(cmp_out_o[1]), 32'h1);
    chk(32'(edge_pulse_o[1]), 32'h1);
    chk(32'(irq_o[1]), 32'h1);
    chk_reg(8'h2C, 32'h3);
    chk_reg(8'h1C, 32'h3);
    chk_reg(8'h48, 32'h3);
    wr(8'h34, 32'h3);
    chk_reg(8'h2C, 32'h0);
    chk(32'(irq_o[1]), 32'h0);
    finish_test();
  end
endmodule : test_analog_comparator_control
bind cac_top cac_checker chk (.sys_clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i,
  .reg_we_i, .reg_re_i, .reg_rdata_o, .cmp_on_o, .mux_on_o, .pos_pick_o,
  .neg_pick_o, .cmp_out_o, .edge_pulse_o, .irq_o);
`default_nettype wire
